/* rtl/sgc_consts.svh */
// Offsets, field positions, reset values and limits of the global control bank
`ifndef SGC_CONSTS_SVH
`define SGC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SGC_IDX_FBC     6'h04
`define SGC_IDX_VPM     6'h05

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SGC_FBC_HUGE    2
`define SGC_FBC_CHKDIS  1
`define SGC_FBC_RSV     0
`define SGC_VPM_VLAN    7
`define SGC_VPM_IGMP    6
`define SGC_VPM_DIRECT  5
`define SGC_VPM_PRETAG  4
`define SGC_VPM_PRIO_HI 3
`define SGC_VPM_PRIO_LO 2
`define SGC_VPM_TAGMASK 1
`define SGC_VPM_SNIFF   0

// ----------------------------------------------------------------
// Reset values and writable bits
// ----------------------------------------------------------------
`define SGC_FBC_RST     8'h00
`define SGC_FBC_WMASK   8'h07
`define SGC_VPM_RST     8'h00

// ----------------------------------------------------------------
// Frame limits, buffer reserve, scheduler ratios, port numbering
// ----------------------------------------------------------------
`define SGC_LEN_HUGE    11'h77c
`define SGC_LEN_NOCHK   11'h600
`define SGC_LEN_TAGGED  11'h5f2
`define SGC_LEN_UNTAG   11'h5ee
`define SGC_HP_RESERVE  6'h30
`define SGC_RATIO_10    4'ha
`define SGC_RATIO_5     4'h5
`define SGC_RATIO_2     4'h2
`define SGC_MII_PORT    3'h4

`endif

/* rtl/sgc_pkg.sv */
// Types shared by the global control bank and its scheduler
package sgc_pkg;

    // Priority scheme codes
    typedef enum logic [1:0] {
        SGC_PRIO_STRICT = 2'h0,
        SGC_PRIO_R10    = 2'h1,
        SGC_PRIO_R5     = 2'h2,
        SGC_PRIO_R2     = 2'h3
    } sgc_prio_e;

endpackage

/* rtl/sgc_prio_sched.sv */
// High/low priority output scheduler steered by the priority scheme field
`timescale 1ns/1ps
`default_nettype none
`include "sgc_consts.svh"

module sgc_prio_sched (
    // Clock, reset, enable
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    // Scheme from the control register
    input  wire sgc_pkg::sgc_prio_e scheme,
    // Queue state and grants
    input  wire logic              hi_pending,
    input  wire logic              lo_pending,
    input  wire logic              slot_free,
    output logic                   grant_hi,
    output logic                   grant_lo
);
    import sgc_pkg::*;

    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [3:0] ratio;
    logic       ghi_r;
    logic       ghi_nxt;
    logic       glo_r;
    logic       glo_nxt;
    logic       hi_turn;

    // Ratio of high frames sent per low frame
    always_comb begin
        case (scheme)
            SGC_PRIO_R10: ratio = `SGC_RATIO_10; // R13
            SGC_PRIO_R5:  ratio = `SGC_RATIO_5;  // R13
            SGC_PRIO_R2:  ratio = `SGC_RATIO_2;  // R13
            default:      ratio = 4'h0;
        endcase
    end

    // Grant choice; a scheme change applies to the next slot
    always_comb begin
        hi_turn = hi_pending && (scheme == SGC_PRIO_STRICT || !lo_pending || cnt_r < ratio); // R12 R13
        cnt_nxt = cnt_r;
        ghi_nxt = 1'b0;
        glo_nxt = 1'b0;
        if (slot_free && hi_turn) begin
            ghi_nxt = 1'b1;
            if (cnt_r < ratio) begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end else if (slot_free && lo_pending) begin
            glo_nxt = 1'b1;
            cnt_nxt = 4'h0;
        end
    end

    // Scheduler state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 4'h0;
            ghi_r <= 1'b0;
            glo_r <= 1'b0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            ghi_r <= ghi_nxt;
            glo_r <= glo_nxt;
        end
    end

    assign grant_hi = ghi_r;
    assign grant_lo = glo_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_strict_hi_first: assert property (ce && slot_free && hi_pending && scheme == SGC_PRIO_STRICT |=> grant_hi && !grant_lo) else $error("strict scheme did not send high first"); // R12
    a_ratio_low_turn: assert property (ce && slot_free && hi_pending && lo_pending && scheme != SGC_PRIO_STRICT && cnt_r == ratio |=> grant_lo) else $error("low frame not sent after ratio"); // R13
    a_ratio_cnt_cap: assert property (scheme == SGC_PRIO_R2 && ce && slot_free && hi_pending && lo_pending ##1 ce && slot_free && hi_pending && lo_pending ##1 ce && slot_free && hi_pending && lo_pending |=> !(grant_hi && $past(grant_hi) && $past(grant_hi, 2))) else $error("ratio 2 exceeded"); // R13
    c_low_served: cover property (grant_lo && scheme == SGC_PRIO_R5);

endmodule
`default_nettype wire

/* rtl/sgc_regs.sv */
// Global switch control bank: frame size, buffers, VLAN, snoop, forward, mirror
// Contract
// R01: Check disabled: accept frames up to 1536
// R02: Check on: 1522 tagged, 1518 untagged
// R03: CPU special-tag frames skip tagged limit
// R04: Drop frames longer than selected limit
// R05: Reserve bit gives 48 high-priority buffers
// R06: Software should set reserve with priority queues
// R07: VLAN bit turns tag-based VLAN on/off
// R08: Software fills VLAN table before enabling
// R09: IGMP snoop forwards IGMP to MII port
// R10: Direct mode forwards port 5 by preamble
// R11: Pre-tag marks MII egress with source port
// R12: Scheme 00 always sends high first
// R13: Schemes 01/10/11 give ratios 10,5,2 to 1
// R14: Tag mask: VID low five bits pick ports
// R15: Sniff set: mirror when both ports match
// R16: Sniff clear: mirror when either matches
// R17: Software uses either-match for receive-only mirror
// R18: Huge bit: accept 1916, overrides check bit
// R19: Control bits act on next frames
`timescale 1ns/1ps
`default_nettype none
`include "sgc_consts.svh"

module sgc_regs (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Strap pin sampled after reset
    input  wire logic        size_limit_strap_pin,
    // Frame size check
    input  wire logic        len_req,
    input  wire logic [10:0] len_bytes,
    input  wire logic        len_tagged,
    input  wire logic        len_cpu_special_tag,
    output logic             len_done,
    output logic             len_drop,
    // Forwarding decision; ports 1..5 are mask bits 0..4
    input  wire logic        fwd_req,
    input  wire logic [2:0]  fwd_src_port,
    input  wire logic [4:0]  fwd_lookup_mask,
    input  wire logic [4:0]  fwd_preamble_mask,
    input  wire logic [11:0] fwd_vid,
    input  wire logic        fwd_tagged,
    input  wire logic        fwd_is_igmp,
    input  wire logic [4:0]  mon_rx_mask,
    input  wire logic [4:0]  mon_tx_mask,
    output logic             fwd_valid,
    output logic [4:0]       fwd_dest_mask,
    output logic             fwd_mirror,
    output logic             fwd_pretag,
    output logic [2:0]       fwd_pretag_port,
    // Output queue scheduler
    input  wire logic        q_hi_pending,
    input  wire logic        q_lo_pending,
    input  wire logic        q_slot_free,
    output logic             q_grant_hi,
    output logic             q_grant_lo,
    // Control levels to the switch core
    output logic             vlan_tag_mode_en,
    output logic [5:0]       hp_reserved_bufs
);
    import sgc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]  fbc_r;
    logic [7:0]  fbc_nxt;
    logic [7:0]  vpm_r;
    logic [7:0]  vpm_nxt;
    logic        dp_wr_r;
    logic        dp_wr_nxt;
    logic        dp_fbc_r;
    logic        dp_fbc_nxt;
    logic        dp_vpm_r;
    logic        dp_vpm_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic [2:0]  strap_sync_r;
    logic [1:0]  fill_r;
    logic [1:0]  fill_nxt;
    logic        strap_done_r;
    logic        strap_done_nxt;
    logic        addr_ok;
    logic        hit_fbc;
    logic        hit_vpm;
    logic [10:0] limit;
    logic        ldone_r;
    logic        ldrop_r;
    logic        ldrop_nxt;
    logic [4:0]  dest;
    logic        rx_hit;
    logic        tx_hit;
    logic        fvalid_r;
    logic [4:0]  fdest_r;
    logic [4:0]  fdest_nxt;
    logic        fmir_r;
    logic        fmir_nxt;
    logic        fptag_r;
    logic        fptag_nxt;
    logic [2:0]  fpport_r;
    logic [2:0]  fpport_nxt;

    // ----------------------------------------------------------------
    // Bus slave and control registers
    // ----------------------------------------------------------------

    // Zero wait states; a low enable stalls the bus instead of losing a transfer
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign hrdata    = rdat_r;

    assign addr_ok = hsel && htrans[1] && hready;
    assign hit_fbc = haddr[7:2] == `SGC_IDX_FBC;
    assign hit_vpm = haddr[7:2] == `SGC_IDX_VPM;

    // Strap pin synchroniser; only stages two and three are compared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_sync_r <= 3'h0;
        end else if (ce) begin
            strap_sync_r <= {strap_sync_r[1:0], size_limit_strap_pin};
        end
    end

    // Next register state; reads see a write landing at the same edge
    always_comb begin
        fbc_nxt        = fbc_r;
        vpm_nxt        = vpm_r;
        fill_nxt       = fill_r;
        strap_done_nxt = strap_done_r;
        dp_wr_nxt      = addr_ok && hwrite;
        dp_fbc_nxt     = addr_ok && hit_fbc;
        dp_vpm_nxt     = addr_ok && hit_vpm;
        rdat_nxt       = rdat_r;
        // Strap is caught once the pipeline has filled and settled
        if (fill_r != 2'h3) begin
            fill_nxt = fill_r + 2'h1;
        end else if (!strap_done_r && strap_sync_r[1] == strap_sync_r[2]) begin
            fbc_nxt[`SGC_FBC_CHKDIS] = strap_sync_r[2];
            strap_done_nxt           = 1'b1;
        end
        // Software write wins over the strap load
        if (dp_wr_r && dp_fbc_r) begin
            fbc_nxt = (fbc_nxt & ~`SGC_FBC_WMASK) | (hwdata[7:0] & `SGC_FBC_WMASK);
        end
        if (dp_wr_r && dp_vpm_r) begin
            vpm_nxt = hwdata[7:0];
        end
        // Unmapped reads return zero
        if (addr_ok && !hwrite) begin
            if (hit_fbc) begin
                rdat_nxt = {24'h0, fbc_nxt};
            end else if (hit_vpm) begin
                rdat_nxt = {24'h0, vpm_nxt};
            end else begin
                rdat_nxt = 32'h0;
            end
        end
    end

    // Register bank state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fbc_r        <= `SGC_FBC_RST;
            vpm_r        <= `SGC_VPM_RST;
            fill_r       <= 2'h0;
            strap_done_r <= 1'b0;
            dp_wr_r      <= 1'b0;
            dp_fbc_r     <= 1'b0;
            dp_vpm_r     <= 1'b0;
            rdat_r       <= 32'h0;
        end else if (ce) begin
            fbc_r        <= fbc_nxt;
            vpm_r        <= vpm_nxt;
            fill_r       <= fill_nxt;
            strap_done_r <= strap_done_nxt;
            dp_wr_r      <= dp_wr_nxt;
            dp_fbc_r     <= dp_fbc_nxt;
            dp_vpm_r     <= dp_vpm_nxt;
            rdat_r       <= rdat_nxt;
        end
    end

    // Core levels follow the registers directly, so no restart is needed
    assign vlan_tag_mode_en = vpm_r[`SGC_VPM_VLAN];                           // R07 R19
    assign hp_reserved_bufs = fbc_r[`SGC_FBC_RSV] ? `SGC_HP_RESERVE : 6'h00; // R05

    // ----------------------------------------------------------------
    // Frame size check
    // ----------------------------------------------------------------

    // With the check on and huge off, special-tag frames from the CPU are held to the untagged limit
    always_comb begin
        if (fbc_r[`SGC_FBC_HUGE]) begin
            limit = `SGC_LEN_HUGE;                          // R18
        end else if (fbc_r[`SGC_FBC_CHKDIS]) begin
            limit = `SGC_LEN_NOCHK;                         // R01
        end else if (len_tagged && !len_cpu_special_tag) begin
            limit = `SGC_LEN_TAGGED;                        // R02 R03
        end else begin
            limit = `SGC_LEN_UNTAG;                         // R02
        end
        ldrop_nxt = len_req ? (len_bytes > limit) : ldrop_r; // R04
    end

    // Verdict registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ldone_r <= 1'b0;
            ldrop_r <= 1'b0;
        end else if (ce) begin
            ldone_r <= len_req;
            ldrop_r <= ldrop_nxt;
        end
    end

    assign len_done = ldone_r;
    assign len_drop = ldrop_r;

    // ----------------------------------------------------------------
    // Forwarding, snooping and mirroring
    // ----------------------------------------------------------------

    // Direct mode beats tag mask, which beats the address lookup
    always_comb begin
        dest = fwd_lookup_mask;
        if (vpm_r[`SGC_VPM_DIRECT] && fwd_src_port == `SGC_MII_PORT) begin
            dest = fwd_preamble_mask;                       // R10
        end else if (vpm_r[`SGC_VPM_TAGMASK] && fwd_tagged) begin
            dest = fwd_vid[4:0];                            // R14
        end
        if (vpm_r[`SGC_VPM_IGMP] && fwd_is_igmp) begin
            dest[`SGC_MII_PORT] = 1'b1;                     // R09
        end
        rx_hit   = mon_rx_mask[fwd_src_port];
        tx_hit   = |(dest & mon_tx_mask);
        fdest_nxt  = fwd_req ? dest : fdest_r;
        fmir_nxt   = fmir_r;
        fptag_nxt  = fptag_r;
        fpport_nxt = fpport_r;
        if (fwd_req) begin
            // Both-match when sniff bit set, either-match otherwise
            fmir_nxt   = vpm_r[`SGC_VPM_SNIFF] ? (rx_hit && tx_hit) : (rx_hit || tx_hit); // R15 R16
            fptag_nxt  = vpm_r[`SGC_VPM_PRETAG] && dest[`SGC_MII_PORT]; // R11
            fpport_nxt = fwd_src_port;
        end
    end

    // Decision registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fvalid_r <= 1'b0;
            fdest_r  <= 5'h00;
            fmir_r   <= 1'b0;
            fptag_r  <= 1'b0;
            fpport_r <= 3'h0;
        end else if (ce) begin
            fvalid_r <= fwd_req;
            fdest_r  <= fdest_nxt;
            fmir_r   <= fmir_nxt;
            fptag_r  <= fptag_nxt;
            fpport_r <= fpport_nxt;
        end
    end

    assign fwd_valid       = fvalid_r;
    assign fwd_dest_mask   = fdest_r;
    assign fwd_mirror      = fmir_r;
    assign fwd_pretag      = fptag_r;
    assign fwd_pretag_port = fpport_r;

    // ----------------------------------------------------------------
    // Output scheduler
    // ----------------------------------------------------------------
    sgc_prio_sched u_sched (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ce         (ce),
        .scheme     (sgc_prio_e'(vpm_r[`SGC_VPM_PRIO_HI:`SGC_VPM_PRIO_LO])), // R12 R13
        .hi_pending (q_hi_pending),
        .lo_pending (q_lo_pending),
        .slot_free  (q_slot_free),
        .grant_hi   (q_grant_hi),
        .grant_lo   (q_grant_lo)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_huge_accept: assert property (ce && len_req && fbc_r[2] && len_bytes <= 11'h77c |=> len_done && !len_drop) else $error("huge frame dropped"); // R18
    a_huge_drop: assert property (ce && len_req && fbc_r[2] && len_bytes == 11'h77d |=> len_drop) else $error("oversize huge frame kept"); // R04
    a_nochk_limit: assert property (ce && len_req && fbc_r[2:1] == 2'b01 |=> len_drop == ($past(len_bytes) > 11'h600)) else $error("1536 limit wrong"); // R01
    a_tagged_limit: assert property (ce && len_req && fbc_r[2:1] == 2'b00 && len_tagged && !len_cpu_special_tag |=> len_drop == ($past(len_bytes) > 11'h5f2)) else $error("tagged limit wrong"); // R02
    a_untag_limit: assert property (ce && len_req && fbc_r[2:1] == 2'b00 && (!len_tagged || len_cpu_special_tag) |=> len_drop == ($past(len_bytes) > 11'h5ee)) else $error("untagged limit wrong"); // R03
    a_reserve_cnt: assert property (hp_reserved_bufs == (fbc_r[0] ? 6'd48 : 6'd0)) else $error("reserved buffer count wrong"); // R05
    a_igmp_to_mii: assert property (ce && fwd_req && fwd_is_igmp && vpm_r[6] |=> fwd_valid && fwd_dest_mask[4]) else $error("igmp not sent to mii"); // R09
    a_direct_fwd: assert property (ce && fwd_req && vpm_r[5] && fwd_src_port == 3'h4 && !(vpm_r[6] && fwd_is_igmp) |=> fwd_dest_mask == $past(fwd_preamble_mask)) else $error("direct mode ignored"); // R10
    a_pretag_mii: assert property (ce && fwd_req ##1 fwd_valid |-> fwd_pretag == ($past(vpm_r[4]) && fwd_dest_mask[4])) else $error("pretag wrong"); // R11
    a_tag_mask: assert property (ce && fwd_req && vpm_r[1] && fwd_tagged && !vpm_r[5] && !fwd_is_igmp |=> fwd_dest_mask == $past(fwd_vid[4:0])) else $error("tag mask ignored"); // R14
    a_sniff_and: assert property (ce && fwd_req && vpm_r[0] && !mon_rx_mask[fwd_src_port] |=> !fwd_mirror) else $error("and-sniff mirrored on tx only"); // R15
    a_sniff_or: assert property (ce && fwd_req && !vpm_r[0] && mon_rx_mask[fwd_src_port] |=> fwd_mirror) else $error("or-sniff missed rx match"); // R16
    a_vlan_level: assert property (ce && dp_wr_r && dp_vpm_r |=> vlan_tag_mode_en == $past(hwdata[7])) else $error("vlan bit not applied"); // R07 R19
    a_read_back: assert property (ce && addr_ok && hwrite && hit_vpm ##1 ce && addr_ok && !hwrite && hit_vpm |=> hrdata == {24'h0, $past(hwdata[7:0])}) else $error("readback mismatch"); // R19

    c_frame_drop:  cover property (len_done && len_drop);
    c_mirror:      cover property (fwd_valid && fwd_mirror && vpm_r[0]);
    c_reg_write:   cover property (ce && dp_wr_r && dp_fbc_r);

endmodule
`default_nettype wire

/* testbench/switch_global_control_regs_test.sv */
// Self-checking bench for the global switch control bank
`timescale 1ns/1ps
`default_nettype none
`include "sgc_consts.svh"

module switch_global_control_regs_test;
    import sgc_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_A = {`SGC_IDX_FBC, 2'b00};
    localparam logic [7:0] ADR_B = {`SGC_IDX_VPM, 2'b00};
    logic        hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, strap;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, fwd_src_port, fwd_pretag_port;
    logic [31:0] hwdata, hrdata;
    logic        len_req, len_tagged, len_cpu_special_tag, len_done, len_drop;
    logic [10:0] len_bytes;
    logic        fwd_req, fwd_tagged, fwd_is_igmp, fwd_valid, fwd_mirror, fwd_pretag;
    logic [4:0]  fwd_lookup_mask, fwd_preamble_mask, mon_rx_mask, mon_tx_mask, fwd_dest_mask;
    logic [11:0] fwd_vid;
    logic        q_hi_pending, q_lo_pending, q_slot_free, q_grant_hi, q_grant_lo;
    logic        vlan_tag_mode_en;
    logic [5:0]  hp_reserved_bufs;
    int          n_fail, check_count;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    sgc_regs i_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .size_limit_strap_pin(strap),
        .len_req(len_req), .len_bytes(len_bytes), .len_tagged(len_tagged),
        .len_cpu_special_tag(len_cpu_special_tag), .len_done(len_done), .len_drop(len_drop),
        .fwd_req(fwd_req), .fwd_src_port(fwd_src_port), .fwd_lookup_mask(fwd_lookup_mask),
        .fwd_preamble_mask(fwd_preamble_mask), .fwd_vid(fwd_vid), .fwd_tagged(fwd_tagged),
        .fwd_is_igmp(fwd_is_igmp), .mon_rx_mask(mon_rx_mask), .mon_tx_mask(mon_tx_mask),
        .fwd_valid(fwd_valid), .fwd_dest_mask(fwd_dest_mask), .fwd_mirror(fwd_mirror),
        .fwd_pretag(fwd_pretag), .fwd_pretag_port(fwd_pretag_port),
        .q_hi_pending(q_hi_pending), .q_lo_pending(q_lo_pending), .q_slot_free(q_slot_free),
        .q_grant_hi(q_grant_hi), .q_grant_lo(q_grant_lo),
        .vlan_tag_mode_en(vlan_tag_mode_en), .hp_reserved_bufs(hp_reserved_bufs)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    // Verdict and end of run, also reached by an exhausted wait
    task automatic stop_test;
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Waits for ready at a rising edge; a stuck slave ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 100) begin
                n_fail++;
                stop_test();
            end
            @(posedge hclk);
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        check("hresp", hresp, 1'b0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(nm, x, e);
    endtask

    // One length check; verdict shows one cycle after the request
    task automatic len(input logic [10:0] n, input logic tg, input logic sp, input logic dr);
        @(posedge hclk);
        len_req             <= 1'b1;
        len_bytes           <= n;
        len_tagged          <= tg;
        len_cpu_special_tag <= sp;
        @(posedge hclk);
        len_req <= 1'b0;
        #1;
        check("len_done", len_done, 1'b1);
        check("len_drop", len_drop, dr);
    endtask

    task automatic fwd(input logic [2:0] s, input logic [4:0] lk, input logic [4:0] pr,
                       input logic [11:0] v, input logic tg, input logic ig,
                       input logic [4:0] rx, input logic [4:0] tx,
                       input logic [4:0] ed, input logic em, input logic ep);
        @(posedge hclk);
        fwd_req           <= 1'b1;
        fwd_src_port      <= s;
        fwd_lookup_mask   <= lk;
        fwd_preamble_mask <= pr;
        fwd_vid           <= v;
        fwd_tagged        <= tg;
        fwd_is_igmp       <= ig;
        mon_rx_mask       <= rx;
        mon_tx_mask       <= tx;
        @(posedge hclk);
        fwd_req <= 1'b0;
        #1;
        check("fwd_valid", fwd_valid, 1'b1);
        check("fwd_dest", fwd_dest_mask, ed);
        check("fwd_mirror", fwd_mirror, em);
        check("fwd_pretag", fwd_pretag, ep);
        check("fwd_port", fwd_pretag_port, s);
    endtask

    task automatic slot(output logic [1:0] g);
        @(posedge hclk);
        q_slot_free <= 1'b1;
        @(posedge hclk);
        q_slot_free <= 1'b0;
        #1;
        g = {q_grant_hi, q_grant_lo};
    endtask

    // A low-only slot clears the run count, then r high grants precede one low; the strict code gives all r+1 slots to high
    task automatic sched(input logic [1:0] sc, input int r);
        logic [1:0] g;
        wr(ADR_B, {24'h0, 4'h0, sc, 2'h0});
        q_hi_pending <= 1'b0;
        q_lo_pending <= 1'b1;
        slot(g);
        check("grant_lo_only", g, 2'h1);
        q_hi_pending <= 1'b1;
        for (int i = 0; i <= r; i++) begin
            slot(g);
            check("grant", g, (i < r || sc == 2'h0) ? 2'h2 : 2'h1);
        end
    endtask

    // ----------------------------------------------------------------
    // Clock and main sequence
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        {hresetn, hsel, hwrite, strap, len_req, len_tagged, len_cpu_special_tag} = '0;
        {fwd_req, fwd_tagged, fwd_is_igmp, q_hi_pending, q_lo_pending, q_slot_free} = '0;
        {haddr, htrans, hwdata, len_bytes, fwd_src_port, fwd_vid} = '0;
        {fwd_lookup_mask, fwd_preamble_mask, mon_rx_mask, mon_tx_mask} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        n_fail = 0;
        check_count = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // Strap sampling settles before the first access
        repeat (6) @(posedge hclk);
        rd_chk("reg_a_reset", ADR_A, 32'h0);
        rd_chk("reg_b_reset", ADR_B, 32'h0);
        wr(8'h18, 32'hff);
        rd_chk("unmapped", 8'h18, 32'h0);
        wr(ADR_A, 32'hff);
        rd_chk("reg_a", ADR_A, 32'h07);
        wr(ADR_B, 32'ha5);
        rd_chk("reg_b", ADR_B, 32'ha5);
        check("vlan_en", vlan_tag_mode_en, 1'b1);
        wr(ADR_B, 32'h0);
        #1;
        check("vlan_en", vlan_tag_mode_en, 1'b0);
        wr(ADR_A, 32'h01);
        #1;
        check("hp_bufs", hp_reserved_bufs, 6'h30);
        wr(ADR_A, 32'h00);
        #1;
        check("hp_bufs", hp_reserved_bufs, 6'h00);
        // Limits around each boundary, switched on the fly
        len(11'h5f2, 1'b1, 1'b0, 1'b0);
        len(11'h5f3, 1'b1, 1'b0, 1'b1);
        len(11'h5ee, 1'b0, 1'b0, 1'b0);
        len(11'h5ef, 1'b0, 1'b0, 1'b1);
        len(11'h5ef, 1'b1, 1'b1, 1'b1);
        wr(ADR_A, 32'h02);
        len(11'h600, 1'b1, 1'b0, 1'b0);
        len(11'h601, 1'b0, 1'b0, 1'b1);
        wr(ADR_A, 32'h07);
        len(11'h77c, 1'b0, 1'b0, 1'b0);
        len(11'h77d, 1'b1, 1'b0, 1'b1);
        // Forwarding: mirror modes, snoop, pre-tag, direct, tag mask
        fwd(3'h0, 5'h06, 5'h00, 12'h000, 1'b0, 1'b1, 5'h01, 5'h00, 5'h06, 1'b1, 1'b0);
        fwd(3'h0, 5'h06, 5'h00, 12'h000, 1'b0, 1'b0, 5'h00, 5'h02, 5'h06, 1'b1, 1'b0);
        wr(ADR_B, 32'h01);
        fwd(3'h0, 5'h06, 5'h00, 12'h000, 1'b0, 1'b0, 5'h01, 5'h00, 5'h06, 1'b0, 1'b0);
        fwd(3'h0, 5'h06, 5'h00, 12'h000, 1'b0, 1'b0, 5'h01, 5'h02, 5'h06, 1'b1, 1'b0);
        wr(ADR_B, 32'h40);
        fwd(3'h1, 5'h06, 5'h00, 12'h000, 1'b0, 1'b1, 5'h00, 5'h00, 5'h16, 1'b0, 1'b0);
        fwd(3'h1, 5'h06, 5'h00, 12'h000, 1'b0, 1'b0, 5'h00, 5'h00, 5'h06, 1'b0, 1'b0);
        wr(ADR_B, 32'h50);
        fwd(3'h2, 5'h06, 5'h00, 12'h000, 1'b0, 1'b1, 5'h00, 5'h00, 5'h16, 1'b0, 1'b1);
        fwd(3'h2, 5'h06, 5'h00, 12'h000, 1'b0, 1'b0, 5'h00, 5'h00, 5'h06, 1'b0, 1'b0);
        wr(ADR_B, 32'h20);
        fwd(3'h4, 5'h06, 5'h0b, 12'h000, 1'b0, 1'b0, 5'h00, 5'h00, 5'h0b, 1'b0, 1'b0);
        fwd(3'h0, 5'h06, 5'h0b, 12'h000, 1'b0, 1'b0, 5'h00, 5'h00, 5'h06, 1'b0, 1'b0);
        wr(ADR_B, 32'h02);
        fwd(3'h0, 5'h06, 5'h00, 12'h0a5, 1'b1, 1'b0, 5'h00, 5'h00, 5'h05, 1'b0, 1'b0);
        fwd(3'h0, 5'h06, 5'h00, 12'h0a5, 1'b0, 1'b0, 5'h00, 5'h00, 5'h06, 1'b0, 1'b0);
        // Scheduler: strict, then every ratio code
        sched(2'h0, 12);
        sched(2'h1, 10);
        sched(2'h2, 5);
        sched(2'h3, 2);
        stop_test();
    end

endmodule
`default_nettype wire
